// ### design/xor_dir_pkg.sv
package xor_dir_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  // Opcode patterns
  localparam logic [10:0] DIRLOAD_PREFIX = 11'h00c; // 00 0000 0110 0 then fff
  localparam logic [5:0] XORW_PREFIX = 6'h06; // 00 0110 d fffffff
  localparam logic [5:0] XORL_PREFIX = 6'h3a; // 11 1010 kkkkkkkk
  localparam logic [2:0] DIR_SEL_MIN = 3'h5;
  localparam logic [2:0] DIR_SEL_MAX = 3'h7;
  // Direction registers in the file map (selectors 5..7 map to 0x05..0x07)
  localparam logic [6:0] DIR_FILE_BASE = 7'h05;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam int NUM_DIR = 3;
endpackage

// ### design/xor_and_direction_load_exec.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - port_direction_load copies work into direction register 5..7; opcode ...0110 0fff.
// - Direction registers are also read and written as ordinary file registers.
// - xor_literal_into_work: work becomes work XOR 8-bit literal; opcode 11 1010.
// - xor_work_with_file: reads addressed file register, XORs it with work.
// - Destination bit 0 writes result to work, file register unchanged.
// - Destination bit 1 writes result to file register, work unchanged.
module xor_and_direction_load_exec #(
  // Direction registers reachable by selector
  parameter int NUM_DIR_REGS = xor_dir_pkg::NUM_DIR
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Instruction from fetch
  input wire logic i_insn_valid,
  input wire logic [xor_dir_pkg::INSN_W-1:0] i_insn,
  // File register read data for the addressed operand
  input wire logic [xor_dir_pkg::DATA_W-1:0] i_file_rdata,
  // Ordinary file access to direction registers from the core datapath
  input wire logic i_dir_wr,
  input wire logic [1:0] i_dir_idx,
  input wire logic [xor_dir_pkg::DATA_W-1:0] i_dir_wdata,
  // File register write-back
  output logic o_file_we,
  output logic [xor_dir_pkg::FADDR_W-1:0] o_file_addr,
  output logic [xor_dir_pkg::DATA_W-1:0] o_file_wdata,
  // Core state
  output logic [xor_dir_pkg::DATA_W-1:0] o_work,
  output logic o_zero_we,
  output logic o_zero,
  output logic [3*xor_dir_pkg::DATA_W-1:0] o_dir,
  output logic o_illegal
);
  import xor_dir_pkg::*;

  // Only selectors 5..7 exist, so storage cannot be sized otherwise
  if (NUM_DIR_REGS != NUM_DIR) begin : g_dir_count_check
    $error("NUM_DIR_REGS must equal the three direction selectors");
  end

  // Reset release synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic nxt_rst_meta;
  logic nxt_rst_sync;

  always_comb begin
    nxt_rst_meta = 1'b1;
    nxt_rst_sync = rst_meta_ff;
  end

  // Assert asynchronously, release on the clock to avoid a partial start
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= nxt_rst_meta;
      rst_sync_ff <= nxt_rst_sync;
    end
  end

  // Architectural and output state
  logic [DATA_W-1:0] work_ff;
  logic [DATA_W-1:0] nxt_work;
  logic [DATA_W-1:0] dir_ff [NUM_DIR_REGS];
  logic [DATA_W-1:0] nxt_dir [NUM_DIR_REGS];
  logic file_we_ff;
  logic nxt_file_we;
  logic [FADDR_W-1:0] file_addr_ff;
  logic [FADDR_W-1:0] nxt_file_addr;
  logic [DATA_W-1:0] file_wdata_ff;
  logic [DATA_W-1:0] nxt_file_wdata;
  logic zero_we_ff;
  logic nxt_zero_we;
  logic zero_ff;
  logic nxt_zero;
  logic illegal_ff;
  logic nxt_illegal;

  // Instruction decode
  logic is_dirload;
  logic is_xorl;
  logic is_xorw;
  logic sel_in_range;
  logic dest_file;
  logic [2:0] sel;
  logic [1:0] dir_slot;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] result;

  always_comb begin
    sel = i_insn[2:0];
    dest_file = i_insn[FADDR_W];
    is_dirload = i_insn_valid && (i_insn[INSN_W-1:3] == DIRLOAD_PREFIX);
    is_xorl = i_insn_valid && (i_insn[INSN_W-1:8] == XORL_PREFIX);
    is_xorw = i_insn_valid && (i_insn[INSN_W-1:8] == XORW_PREFIX);
    sel_in_range = (sel >= DIR_SEL_MIN) && (sel <= DIR_SEL_MAX);
    dir_slot = 2'(sel - DIR_SEL_MIN);
    // One shared XOR serves both forms; only the operand differs
    operand = is_xorl ? i_insn[DATA_W-1:0] : i_file_rdata;
    result = work_ff ^ operand;
  end

  // Working register
  always_comb begin
    nxt_work = work_ff;
    if (is_xorl) begin
      nxt_work = result;
    end else if (is_xorw && !dest_file) begin
      nxt_work = result;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      work_ff <= WORK_RESET;
    end else begin
      work_ff <= nxt_work;
    end
  end

  // Direction registers
  always_comb begin
    nxt_dir = dir_ff;
    // Ordinary write first, so a same-cycle load overrides it
    if (i_dir_wr && (i_dir_idx < 2'(NUM_DIR_REGS))) begin
      nxt_dir[i_dir_idx] = i_dir_wdata;
    end
    if (is_dirload && sel_in_range) begin
      nxt_dir[dir_slot] = work_ff;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      for (int i = 0; i < NUM_DIR_REGS; i++) begin
        dir_ff[i] <= DIR_RESET;
      end
    end else begin
      dir_ff <= nxt_dir;
    end
  end

  // File register write-back; address and data hold between writes
  always_comb begin
    nxt_file_we = 1'b0;
    nxt_file_addr = file_addr_ff;
    nxt_file_wdata = file_wdata_ff;
    if (is_xorw && dest_file) begin
      nxt_file_we = 1'b1;
      nxt_file_addr = i_insn[FADDR_W-1:0];
      nxt_file_wdata = result;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      file_we_ff <= 1'b0;
      file_addr_ff <= '0;
      file_wdata_ff <= '0;
    end else begin
      file_we_ff <= nxt_file_we;
      file_addr_ff <= nxt_file_addr;
      file_wdata_ff <= nxt_file_wdata;
    end
  end

  // Zero flag leaves as value plus strobe; status register lives outside
  always_comb begin
    nxt_zero_we = 1'b0;
    nxt_zero = zero_ff;
    if (is_xorl || is_xorw) begin
      nxt_zero_we = 1'b1;
      nxt_zero = (result == '0);
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      zero_we_ff <= 1'b0;
      zero_ff <= 1'b0;
    end else begin
      zero_we_ff <= nxt_zero_we;
      zero_ff <= nxt_zero;
    end
  end

  // Out-of-range selector changes nothing, only raises a pulse
  always_comb begin
    nxt_illegal = is_dirload && !sel_in_range;
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      illegal_ff <= 1'b0;
    end else begin
      illegal_ff <= nxt_illegal;
    end
  end

  // Outputs straight from flip-flops
  assign o_work = work_ff;
  assign o_file_we = file_we_ff;
  assign o_file_addr = file_addr_ff;
  assign o_file_wdata = file_wdata_ff;
  assign o_zero_we = zero_we_ff;
  assign o_zero = zero_ff;
  assign o_illegal = illegal_ff;
  assign o_dir = {dir_ff[2], dir_ff[1], dir_ff[0]};
endmodule
`default_nettype wire

// ### test/regfile_model.sv
`timescale 1ns/100ps
`default_nettype none
module regfile_model (
  input wire logic [6:0] i_ra,
  output logic [7:0] o_rd
);
  assign o_rd = {i_ra[3:0], i_ra[6:3]} ^ 8'h5a;
endmodule
`default_nettype wire

// ### test/xor_exec_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module xchk (
  input wire logic i_clk_sys, i_nrst, i_insn_valid, i_dir_wr, o_file_we, o_zero,
  input wire logic [13:0] i_insn,
  input wire logic [7:0] i_file_rdata, i_dir_wdata, o_file_wdata, o_work,
  input wire logic [1:0] i_dir_idx,
  input wire logic [23:0] o_dir
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  wire dl = i_insn_valid && i_insn[13:3] == 11'h00c && i_insn[2:0] > 3'h4;
  wire xw = i_insn_valid && i_insn[13:8] == 6'h06;
  wire xl = i_insn_valid && i_insn[13:8] == 6'h3a;
  wire dw = i_dir_wr && i_dir_idx < 2'h3;
  wire [7:0] r = o_work ^ (xl ? i_insn[7:0] : i_file_rdata);
  property p_dl; dl |=> o_dir[8*$past(i_insn[1:0]-2'h1)+:8] == $past(o_work); endproperty
  a_dl: assert property (p_dl) else $error("dl");
  property p_dw; dw |=> o_dir[8*$past(i_dir_idx)+:8] == $past(i_dir_wdata); endproperty
  a_dw: assert property (p_dw) else $error("dw");
  property p_xl; xl |=> o_work == $past(r); endproperty
  a_xl: assert property (p_xl) else $error("xl");
  property p_x1; xw && i_insn[7] |=> o_file_wdata == $past(r); endproperty
  a_x1: assert property (p_x1) else $error("x1");
  property p_x0; xw && !i_insn[7] |=> o_work == $past(r); endproperty
  a_x0: assert property (p_x0) else $error("x0");
  property p_we; o_file_we == $past(xw && i_insn[7]); endproperty
  a_we: assert property (p_we) else $error("we");
  property p_z; xl || xw |=> o_zero == ($past(r) == 8'h00); endproperty
  a_z: assert property (p_z) else $error("z");
endmodule
bind xor_and_direction_load_exec xchk u_xchk (.*);
`default_nettype wire

// ### test/xor_and_direction_load_exec_test.sv
`timescale 1ns/100ps
`default_nettype none
module xor_and_direction_load_exec_test;
  logic i_clk_sys, i_nrst, i_insn_valid, i_dir_wr, o_file_we, o_zero_we, o_zero, o_illegal;
  logic [13:0] i_insn;
  logic [1:0] i_dir_idx;
  logic [7:0] i_dir_wdata, i_file_rdata, o_file_wdata, o_work, w, fd;
  logic [6:0] o_file_addr, fa;
  logic [23:0] o_dir, dv;
  logic fwe, zwe, z, ill;
  int bad_count, n_checks, seed = 85, cyc, r;
  xor_and_direction_load_exec u_xor_and_direction_load_exec (.*);
  regfile_model u_regfile_model (.i_ra(i_insn[6:0]), .o_rd(i_file_rdata));
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) if (++cyc > 900) begin bad_count++; give_verdict; end
  task give_verdict;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] a, e);
    n_checks++;
    if (a !== e) begin bad_count++; $display("[ERR] %0t %h %h", $time, a, e); end
  endtask
  task chk24(input logic [23:0] a, e);
    n_checks++;
    if (a !== e) begin bad_count++; $display("[ERR] %0t %h %h", $time, a, e); end
  endtask
  task chk1(input logic a, e);
    n_checks++;
    if (a !== e) begin bad_count++; $display("[ERR] %0t %h %h", $time, a, e); end
  endtask
  function automatic logic [7:0] xor_exp(input logic [13:0] i, input logic [7:0] wv, fv);
    return wv ^ ((i[13:8] == 6'h3a) ? i[7:0] : fv);
  endfunction
  // Expected state once the instruction just driven is taken
  task predict(input logic [13:0] i, input logic wr);
    logic [7:0] x;
    {fwe, zwe, ill} = 3'h0;
    x = xor_exp(i, w, i_file_rdata);
    if (wr && i_dir_idx != 2'h3) dv[8*i_dir_idx+:8] = i_dir_wdata;
    else if (!wr && i[13:3] == 11'h00c && i[2:0] >= 3'h5) dv[8*(i[2:0]-3'h5)+:8] = w;
    else if (!wr && i[13:3] == 11'h00c) ill = 1'b1;
    else if (!wr && (i[13:8] == 6'h3a || i[13:8] == 6'h06)) begin
      {zwe, z} = {1'b1, x == 8'h00};
      if (i[13:7] == 7'h0d) {fwe, fa, fd} = {1'b1, i[6:0], x};
      else w = x;
    end
  endtask
  // Dir writes only on idle cycles, so no clash with a dir load
  task go(input logic [13:0] i, input logic wr);
    @(posedge i_clk_sys);
    #1;
    chk(o_work, w);
    chk24(o_dir, dv);
    chk1(o_file_we, fwe);
    chk({1'b0, o_file_addr}, {1'b0, fa});
    chk(o_file_wdata, fd);
    chk1(o_zero_we, zwe);
    chk1(o_zero, z);
    chk1(o_illegal, ill);
    {i_insn, i_insn_valid, i_dir_wr, i_dir_idx, i_dir_wdata} = {i, !wr, wr, 10'($random(seed))};
    #1;
    predict(i, wr);
  endtask
  initial begin
    {i_nrst, i_insn_valid, i_dir_wr, i_insn, i_dir_idx, i_dir_wdata} = '0;
    {w, fd, fa, fwe, zwe, z, ill} = '0;
    dv = '1;
    repeat (8) @(posedge i_clk_sys);
    #1 i_nrst = 1'h1;
    repeat (3) @(posedge i_clk_sys);
    go(14'h3ab5, 1'h0);
    go(14'h3aaf, 1'h0);
    go(14'h3a1a, 1'h0);
    chk(o_work, 8'h1a);
    go(14'h0065, 1'h0);
    chk1(o_zero, 1'b1);
    go(14'h0062, 1'h0);
    $display("corner done");
    repeat (500) begin
      r = $random(seed);
      go(r[18] ? {11'h00c, r[2:0]} : {r[17] ? 6'h3a : 6'h06, r[7:0]}, r[20]);
    end
    go(14'h0000, 1'h0);
    $display("random done");
    give_verdict;
  end
endmodule
`default_nettype wire
